// file: design/otp_port_cfg.svh
// Timing counts, mode codes and sizes for the slave programming port.
// Assumes the device clock is also the oscillator that all intervals count.
`ifndef OTP_PORT_CFG_SVH
`define OTP_PORT_CFG_SVH

// Clock and oscillator period
`define OTP_CLK_PERIOD_NS      10
`define OTP_OSC_PERIOD_NS      10
`define OTP_CLK_PER_OSC        (`OTP_OSC_PERIOD_NS / `OTP_CLK_PERIOD_NS)

// Device-side limits, in oscillator periods
`define OTP_VERIFY_HOLD_OSC    50
`define OTP_VERIFY_HOLD_CYC    (`OTP_VERIFY_HOLD_OSC * `OTP_CLK_PER_OSC)
`define OTP_LATCH_TO_VFY_OSC   60
`define OTP_PULSE_TO_VFY_OSC   90
`define OTP_DUMP_VALID_OSC     50

// Storage geometry
`define OTP_ADDR_W             12
`define OTP_DATA_W             16
`define OTP_DEPTH              4096
`define OTP_ERASED_WORD        16'hFFFF

// Mode pin codes
`define OTP_MODE_PROGRAM       2'h0
`define OTP_MODE_DUMP          2'h1
`define OTP_MODE_VERIFY        2'h2

// Synchroniser bit positions
`define OTP_SYNC_W             5
`define OTP_SYNC_RESET         0
`define OTP_SYNC_LATCH         1
`define OTP_SYNC_PULSE         2
`define OTP_SYNC_INCR          3
`define OTP_SYNC_MODE0         4
// Idle pin levels: strobes high, programmer reset and mode bit low
`define OTP_SYNC_IDLE          5'h0E

`endif

// file: design/otp_port_pkg.sv
// Types shared by the programming port and its storage.
// Assumes otp_port_cfg.svh is on the include path.
`include "otp_port_cfg.svh"

package otp_port_pkg;

   typedef logic [`OTP_ADDR_W-1:0] addr_t;
   typedef logic [`OTP_DATA_W-1:0] word_t;
   typedef logic [1:0]             mode_t;

   // Gray codes along idle, ready, pulse, check
   typedef enum logic [1:0] {
      st_idle  = 2'h0,
      st_ready = 2'h1,
      st_pulse = 2'h3,
      st_check = 2'h2
   } port_state_e;

endpackage : otp_port_pkg

// file: design/otp_array.sv
// One-time-programmable word storage held in flip-flops.
// Assumes writes come from the port controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "otp_port_cfg.svh"

module otp_array (
   // Clock, reset, enable
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               clk_en,
   // Write port: clears bits only
   input  wire logic               wr_en,
   input  wire otp_port_pkg::addr_t wr_addr,
   input  wire otp_port_pkg::word_t wr_data,
   // Read port, combinational
   input  wire otp_port_pkg::addr_t rd_addr,
   output otp_port_pkg::word_t      rd_data
);

   otp_port_pkg::word_t mem_q [`OTP_DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // Storage: a write never returns a programmed zero to one; only rst reloads the erased word
   genvar gi;
   generate
      for (gi = 0; gi < `OTP_DEPTH; gi++) begin : g_word
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               mem_q[gi] <= `OTP_ERASED_WORD;
            end else if (clk_en && wr_en && (wr_addr == otp_port_pkg::addr_t'(gi))) begin
               mem_q[gi] <= mem_q[gi] & wr_data;
            end
         end
      end
   endgenerate

   assign rd_data = mem_q[rd_addr];

endmodule : otp_array
`default_nettype wire

// file: design/otp_slave_port.sv
// Slave-mode programming port: latches an address, programs, verifies
// or dumps words under strobes from an external programmer.
// Assumes all strobe, mode and bus pins are asynchronous to ref_clk and
// that the programmer keeps its own spacing between strobes.
`timescale 1ns/1ps
`default_nettype none
`include "otp_port_cfg.svh"

module otp_slave_port (
   // Clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                clk_en,
   // Programmer strobes, active low
   input  wire logic                program_pulse_reset_n,
   input  wire logic                program_address_latch_strobe_n,
   input  wire logic                program_pulse_n,
   input  wire logic                address_increment_strobe_n,
   // Mode select
   input  wire logic [1:0]          mode_sel,
   // Address and data pins
   input  wire otp_port_pkg::addr_t addr_in,
   input  wire otp_port_pkg::word_t data_in,
   output otp_port_pkg::word_t      data_out,
   output logic                     data_oe,
   // Status
   output logic                     program_verify_flag
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic [`OTP_SYNC_W-1:0] sync1_q;
   logic [`OTP_SYNC_W-1:0] sync2_q;
   logic [`OTP_SYNC_W-1:0] sync_prev_q;
   logic [`OTP_SYNC_W-1:0] sync_raw;
   logic                   mode1_s1_q;
   logic                   mode1_s2_q;
   logic [`OTP_SYNC_W-1:0] sync_idle;

   // Reset to idle levels, else a false live port or edge follows reset
   assign sync_idle = `OTP_SYNC_IDLE;

   assign sync_raw = {mode_sel[0], address_increment_strobe_n, program_pulse_n,
                      program_address_latch_strobe_n, program_pulse_reset_n};

   genvar gi;
   generate
      for (gi = 0; gi < `OTP_SYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sync1_q[gi]     <= sync_idle[gi];
               sync2_q[gi]     <= sync_idle[gi];
               sync_prev_q[gi] <= sync_idle[gi];
            end else if (clk_en) begin
               sync1_q[gi]     <= sync_raw[gi];
               sync2_q[gi]     <= sync1_q[gi];
               sync_prev_q[gi] <= sync2_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode1_s1_q <= 1'b0;
         mode1_s2_q <= 1'b0;
      end else if (clk_en) begin
         mode1_s1_q <= mode_sel[1];
         mode1_s2_q <= mode1_s1_q;
      end
   end

   // Bus pins are registered every cycle and used once a strobe edge has crossed, so they
   // have had two cycles to settle; the programmer holds them long enough
   otp_port_pkg::addr_t addr_s_q;
   otp_port_pkg::word_t data_s_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_s_q <= '0;
         data_s_q <= '0;
      end else if (clk_en) begin
         addr_s_q <= addr_in;
         data_s_q <= data_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge detection
   logic               port_live;
   logic               latch_fall;
   logic               pulse_fall;
   logic               pulse_rise;
   logic               incr_fall;
   otp_port_pkg::mode_t mode;

   assign port_live  = sync2_q[`OTP_SYNC_RESET];
   assign latch_fall = sync_prev_q[`OTP_SYNC_LATCH] & ~sync2_q[`OTP_SYNC_LATCH];
   assign pulse_fall = sync_prev_q[`OTP_SYNC_PULSE] & ~sync2_q[`OTP_SYNC_PULSE];
   assign pulse_rise = ~sync_prev_q[`OTP_SYNC_PULSE] & sync2_q[`OTP_SYNC_PULSE];
   assign incr_fall  = sync_prev_q[`OTP_SYNC_INCR] & ~sync2_q[`OTP_SYNC_INCR];
   assign mode       = {mode1_s2_q, sync2_q[`OTP_SYNC_MODE0]};

   ////////////////////////////////////////////////////////////////////////
   // Sequence state
   otp_port_pkg::port_state_e state_q;
   otp_port_pkg::port_state_e state_d;
   logic [5:0]                hold_cnt_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         otp_port_pkg::st_idle: begin
            if (port_live) begin
               state_d = otp_port_pkg::st_ready;
            end
         end
         otp_port_pkg::st_ready: begin
            if (pulse_fall) begin
               state_d = otp_port_pkg::st_pulse;
            end
         end
         otp_port_pkg::st_pulse: begin
            if (pulse_rise) begin
               state_d = otp_port_pkg::st_check;
            end
         end
         otp_port_pkg::st_check: begin
            // Wait out the increment hold before touching the flag
            if (hold_cnt_q == 6'h00) begin
               state_d = otp_port_pkg::st_ready;
            end
         end
         default: begin
            state_d = otp_port_pkg::st_idle;
         end
      endcase
      if (!port_live) begin
         state_d = otp_port_pkg::st_idle;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= otp_port_pkg::st_idle;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address: relatched by the latch strobe, stepped by the increment
   otp_port_pkg::addr_t addr_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_q <= '0;
      end else if (clk_en) begin
         if (!port_live) begin
            addr_q <= '0;
         end else if (latch_fall) begin
            addr_q <= addr_s_q;
         end else if (incr_fall) begin
            addr_q <= addr_q + otp_port_pkg::addr_t'(1);
         end
      end
   end

   // Flag hold window after an increment
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_cnt_q <= 6'h00;
      end else if (clk_en) begin
         if (incr_fall) begin
            hold_cnt_q <= 6'(`OTP_VERIFY_HOLD_CYC);
         end else if (hold_cnt_q != 6'h00) begin
            hold_cnt_q <= hold_cnt_q - 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage access
   otp_port_pkg::word_t rd_word;
   otp_port_pkg::word_t wdata_q;
   logic                wr_en;

   // Each pulse clears bits again, so repeated pulses are harmless
   assign wr_en = pulse_fall && (state_q == otp_port_pkg::st_ready)
                  && (mode == `OTP_MODE_PROGRAM);

   otp_array u_array (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .wr_en   (wr_en),
      .wr_addr (addr_q),
      .wr_data (data_s_q),
      .rd_addr (addr_q),
      .rd_data (rd_word)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdata_q <= '0;
      end else if (clk_en && pulse_fall && (state_q == otp_port_pkg::st_ready)) begin
         wdata_q <= data_s_q;
      end
   end

   // Result taken before an increment can move the read address
   logic                match_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         match_q <= 1'b0;
      end else if (clk_en && pulse_rise && (state_q == otp_port_pkg::st_pulse)) begin
         match_q <= (rd_word == wdata_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Verify flag: high only when the word matches after a pulse
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         program_verify_flag <= 1'b0;
      end else if (clk_en) begin
         if (!port_live || latch_fall) begin
            program_verify_flag <= 1'b0;
         end else if ((state_q == otp_port_pkg::st_check) && (hold_cnt_q == 6'h00)) begin
            program_verify_flag <= (mode != `OTP_MODE_DUMP)
                                   && match_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word dump drive, released as the pulse returns high
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_out <= '0;
         data_oe  <= 1'b0;
      end else if (clk_en) begin
         if (!port_live || pulse_rise) begin
            data_oe <= 1'b0;
         end else if (pulse_fall && (mode == `OTP_MODE_DUMP)) begin
            data_out <= rd_word;
            data_oe  <= 1'b1;
         end
      end
   end

endmodule : otp_slave_port
`default_nettype wire

// file: bench/otp_slave_port_sva.sv
// Checker for the slave programming port outputs.
// Assumes it is bound to otp_slave_port; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "otp_port_cfg.svh"

module otp_slave_port_chk (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Strobes and mode
   input wire logic       program_address_latch_strobe_n,
   input wire logic       program_pulse_n,
   input wire logic       address_increment_strobe_n,
   input wire logic [1:0] mode_sel,
   // Status
   input wire logic       data_oe,
   input wire logic       program_verify_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Hold window after a step strobe; counter keeps the repetition short
   logic [5:0] hold_q;
   always_ff @(posedge ref_clk) begin
      if (rst)
         hold_q <= 6'h00;
      else if ($fell(address_increment_strobe_n))
         hold_q <= 6'h32;
      else if (hold_q != 6'h00)
         hold_q <= hold_q - 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_vfy_hold;
      hold_q != 6'h00 |-> $stable(program_verify_flag);
   endproperty
   a_vfy_hold: assert property (p_vfy_hold)
      else $error("flag moved inside step hold");
   property p_latch_vfy;
      $fell(program_address_latch_strobe_n) |-> ##[1:60] !program_verify_flag;
   endproperty
   a_latch_vfy: assert property (p_latch_vfy)
      else $error("flag not low after latch");
   property p_pulse_vfy;
      $rose(program_pulse_n) |-> ##90 $stable(program_verify_flag)[*8];
   endproperty
   a_pulse_vfy: assert property (p_pulse_vfy)
      else $error("flag not settled after pulse");
   property p_dump_on;
      (mode_sel == `OTP_MODE_DUMP) && $fell(program_pulse_n) |-> ##[1:50] data_oe;
   endproperty
   a_dump_on: assert property (p_dump_on)
      else $error("dump word late");
   property p_dump_off;
      data_oe && $rose(program_pulse_n) |-> ##[1:50] !data_oe;
   endproperty
   a_dump_off: assert property (p_dump_off)
      else $error("dump drive held too long");
   property p_oe_mode;
      data_oe |-> mode_sel == `OTP_MODE_DUMP;
   endproperty
   a_oe_mode: assert property (p_oe_mode)
      else $error("data driven outside dump");

   c_dump: cover property ($rose(data_oe));
   c_match: cover property ($rose(program_verify_flag));
   c_hold: cover property (hold_q == 6'h01);
endmodule : otp_slave_port_chk

bind otp_slave_port otp_slave_port_chk i_otp_slave_port_chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .program_address_latch_strobe_n(program_address_latch_strobe_n),
   .program_pulse_n(program_pulse_n),
   .address_increment_strobe_n(address_increment_strobe_n),
   .mode_sel(mode_sel),
   .data_oe(data_oe),
   .program_verify_flag(program_verify_flag)
);
`default_nettype wire

// file: bench/otp_programmer.sv
// External programmer model driving strobes, mode and buses.
// Assumes one oscillator period per ref_clk cycle.
`timescale 1ns/1ps
`default_nettype none

module otp_programmer (
   // Clock
   input  wire logic           ref_clk,
   // Strobes, active low
   output logic                program_pulse_reset_n,
   output logic                program_address_latch_strobe_n,
   output logic                program_pulse_n,
   output logic                address_increment_strobe_n,
   // Mode and buses
   output logic [1:0]          mode_sel,
   output otp_port_pkg::addr_t addr_in,
   output otp_port_pkg::word_t data_in
);
   initial begin
      program_pulse_reset_n = 1'b0;
      program_address_latch_strobe_n = 1'b1;
      program_pulse_n = 1'b1;
      address_increment_strobe_n = 1'b1;
      mode_sel = 2'h0;
      addr_in = 12'h000;
      data_in = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic start();
      @(posedge ref_clk);
      program_pulse_reset_n <= 1'b1;
      cyc(1100);
   endtask : start

   task automatic latch(input logic [1:0] m, input otp_port_pkg::addr_t a);
      @(posedge ref_clk);
      mode_sel <= m;
      addr_in <= a;
      program_address_latch_strobe_n <= 1'b0;
      cyc(40);
      program_address_latch_strobe_n <= 1'b1;
      cyc(10);
      // Released bus flips so a late sample shows up
      addr_in <= ~a;
      cyc(210);
   endtask : latch

   task automatic pulse_lo(input otp_port_pkg::word_t d);
      @(posedge ref_clk);
      data_in <= d;
      program_pulse_n <= 1'b0;
      cyc(40);
   endtask : pulse_lo

   task automatic pulse_hi();
      @(posedge ref_clk);
      program_pulse_n <= 1'b1;
      cyc(10);
      data_in <= ~data_in;
      cyc(110);
   endtask : pulse_hi

   // Pulse end and step strobe on the same edge, the tightest legal case
   task automatic pulse_hi_step();
      @(posedge ref_clk);
      program_pulse_n <= 1'b1;
      address_increment_strobe_n <= 1'b0;
      cyc(10);
      data_in <= ~data_in;
      cyc(30);
      address_increment_strobe_n <= 1'b1;
      cyc(130);
   endtask : pulse_hi_step

   task automatic incr();
      @(posedge ref_clk);
      address_increment_strobe_n <= 1'b0;
      cyc(40);
      address_increment_strobe_n <= 1'b1;
      cyc(130);
   endtask : incr
endmodule : otp_programmer
`default_nettype wire

// file: bench/otp_slave_programming_port_tb_top.sv
// Self-checking bench for the slave programming port.
// Assumes the programmer model keeps all strobe spacing.
`timescale 1ns/1ps
`default_nettype none
`include "otp_port_cfg.svh"

module otp_slave_programming_port_tb_top;
   logic                ref_clk = 1'b0;
   logic                rst = 1'b1;
   logic                clk_en = 1'b1;
   logic                program_pulse_reset_n;
   logic                program_address_latch_strobe_n;
   logic                program_pulse_n;
   logic                address_increment_strobe_n;
   logic [1:0]          mode_sel;
   otp_port_pkg::addr_t addr_in;
   otp_port_pkg::word_t data_in;
   otp_port_pkg::word_t data_out;
   logic                data_oe;
   logic                program_verify_flag;
   int                  errors = 0;
   int                  checks = 0;

   always #5 ref_clk = ~ref_clk;

   otp_slave_port i_otp_slave_port (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .program_pulse_reset_n(program_pulse_reset_n),
      .program_address_latch_strobe_n(program_address_latch_strobe_n),
      .program_pulse_n(program_pulse_n),
      .address_increment_strobe_n(address_increment_strobe_n),
      .mode_sel(mode_sel), .addr_in(addr_in), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe),
      .program_verify_flag(program_verify_flag)
   );
   otp_programmer i_otp_programmer (
      .ref_clk(ref_clk), .program_pulse_reset_n(program_pulse_reset_n),
      .program_address_latch_strobe_n(program_address_latch_strobe_n),
      .program_pulse_n(program_pulse_n),
      .address_increment_strobe_n(address_increment_strobe_n),
      .mode_sel(mode_sel), .addr_in(addr_in), .data_in(data_in)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic chk_flag(input logic e);
      #1;
      chk("flag", 16'(program_verify_flag), 16'(e));
   endtask : chk_flag

   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////
   task automatic t_program();
      i_otp_programmer.latch(`OTP_MODE_PROGRAM, 12'h123);
      i_otp_programmer.pulse_lo(16'h5A5A);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      i_otp_programmer.latch(`OTP_MODE_PROGRAM, 12'h124);
      chk_flag(1'b0);
      i_otp_programmer.pulse_lo(16'h00FF);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      $display("done program");
   endtask : t_program

   task automatic t_verify();
      i_otp_programmer.latch(`OTP_MODE_VERIFY, 12'h123);
      i_otp_programmer.pulse_lo(16'h5A5A);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      i_otp_programmer.pulse_lo(16'h1234);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b0);
      i_otp_programmer.incr();
      i_otp_programmer.pulse_lo(16'h00FF);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      $display("done verify");
   endtask : t_verify

   task automatic t_dump();
      i_otp_programmer.latch(`OTP_MODE_DUMP, 12'h123);
      i_otp_programmer.pulse_lo(16'h0000);
      #1;
      chk("oe", 16'(data_oe), 16'h0001);
      chk("word", data_out, 16'h5A5A);
      i_otp_programmer.pulse_hi();
      #1;
      chk("oe", 16'(data_oe), 16'h0000);
      i_otp_programmer.incr();
      i_otp_programmer.pulse_lo(16'h0000);
      #1;
      chk("word", data_out, 16'h00FF);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b0);
      $display("done dump");
   endtask : t_dump

   task automatic t_repeat();
      i_otp_programmer.latch(`OTP_MODE_PROGRAM, 12'h200);
      repeat (2) begin
         i_otp_programmer.pulse_lo(16'hF0F0);
         i_otp_programmer.pulse_hi();
      end
      i_otp_programmer.incr();
      i_otp_programmer.pulse_lo(16'h0F0F);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      i_otp_programmer.latch(`OTP_MODE_VERIFY, 12'h201);
      i_otp_programmer.pulse_lo(16'h0F0F);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      $display("done repeat");
   endtask : t_repeat

   // Step right at pulse end: flag reports the pulsed word, not the next
   task automatic t_hold_freeze();
      i_otp_programmer.latch(`OTP_MODE_VERIFY, 12'h123);
      i_otp_programmer.pulse_lo(16'h5A5A);
      i_otp_programmer.pulse_hi_step();
      chk_flag(1'b1);
      @(posedge ref_clk);
      clk_en <= 1'b0;
      i_otp_programmer.pulse_lo(16'h1111);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b1);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      i_otp_programmer.pulse_lo(16'h1111);
      i_otp_programmer.pulse_hi();
      chk_flag(1'b0);
      $display("done hold");
   endtask : t_hold_freeze

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      i_otp_programmer.start();
      t_program();
      t_verify();
      t_dump();
      t_repeat();
      t_hold_freeze();
      final_report();
   end

   // Run needs about 5800 cycles; a hang stops well past that
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      final_report();
   end
endmodule : otp_slave_programming_port_tb_top
`default_nettype wire
